/* src/counter_array_pkg.sv */
// Constants, modes and decode helpers for the counter array compare block
package counter_array_pkg;

    localparam int NUM_MODULES     = 5;
    localparam int WATCHDOG_MODULE = 4;

    // Register offsets on the byte-wide register port
    localparam logic [4:0] ARRAY_CONTROL_OFS = 5'h00;
    localparam logic [4:0] ARRAY_MODE_OFS    = 5'h01;
    localparam logic [4:0] COUNTER_LOW_OFS   = 5'h02;
    localparam logic [4:0] COUNTER_HIGH_OFS  = 5'h03;
    localparam logic [4:0] MODULE_MODE_OFS   = 5'h04;
    localparam logic [4:0] COMPARE_LOW_OFS   = 5'h09;
    localparam logic [4:0] COMPARE_HIGH_OFS  = 5'h0e;

    // array_control_reg fields
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int COUNTER_RUN_BIT   = 6;

    // array_mode_reg fields
    localparam int IDLE_SUSPEND_BIT   = 7;
    localparam int WD_ENABLE_BIT      = 6;
    localparam int WD_LOCK_BIT        = 5;
    localparam int TIMEBASE_LSB       = 1;
    localparam int OVERFLOW_IRQ_BIT   = 0;

    // module_mode_reg fields
    localparam int SIXTEEN_BIT_SEL_BIT = 7;
    localparam int COMPARE_ENABLE_BIT  = 6;
    localparam int CAPTURE_RISE_BIT    = 5;
    localparam int CAPTURE_FALL_BIT    = 4;
    localparam int EQUAL_EVENT_BIT     = 3;
    localparam int FLIP_ON_EQUAL_BIT   = 2;
    localparam int MODULATOR_BIT       = 1;
    localparam int MODULE_IRQ_BIT      = 0;

    // Reset values
    localparam logic [7:0]  ARRAY_MODE_RESET  = 8'h40;
    localparam logic [7:0]  MODULE_MODE_RESET = 8'h00;
    localparam logic [7:0]  COMPARE_RESET     = 8'h00;
    localparam logic [15:0] COUNTER_RESET     = 16'h0000;

    // Timebase codes and divider terminal counts
    localparam logic [2:0] TIMEBASE_DIV12  = 3'h0;
    localparam logic [2:0] TIMEBASE_DIV4   = 3'h1;
    localparam logic [2:0] TIMEBASE_SYSCLK = 3'h4;
    localparam logic [3:0] DIV12_LAST      = 4'hb;
    localparam logic [3:0] DIV4_LAST       = 4'h3;

    typedef enum logic [2:0] {
        MODE_OFF, MODE_TIMER, MODE_HSO, MODE_FREQ, MODE_PWM8, MODE_PWM16, MODE_WATCHDOG
    } compare_mode_t;

    function automatic compare_mode_t decode_mode(input logic [7:0] m);
        logic ecom;
        logic pwm;
        logic tog;
        logic mat;
        ecom = m[COMPARE_ENABLE_BIT];
        pwm  = m[MODULATOR_BIT];
        tog  = m[FLIP_ON_EQUAL_BIT];
        mat  = m[EQUAL_EVENT_BIT];
        if (m[CAPTURE_RISE_BIT] || m[CAPTURE_FALL_BIT])
            return MODE_OFF;
        else if (pwm && tog)
            return ecom ? MODE_FREQ : MODE_OFF;
        else if (pwm)
            return m[SIXTEEN_BIT_SEL_BIT] ? MODE_PWM16 : MODE_PWM8;
        else if (ecom && mat)
            return tog ? MODE_HSO : MODE_TIMER;
        else
            return MODE_OFF;
    endfunction

endpackage

/* src/counter_array_compare_watchdog.sv */
// Counter array: shared counter, five compare modules and the module 4 watchdog
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module counter_array_compare_watchdog
    import counter_array_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       cpu_idle,
    input  wire logic       timebase_event,
    output logic      [4:0] module_io_line,
    output logic      [4:0] module_io_oe,
    output logic            irq_request,
    output logic            watchdog_reset
);

    // Array-level state
    logic        overflow_flag;
    logic        counter_run;
    logic [4:0]  module_event_flag;
    logic        idle_suspend;
    logic        watchdog_enable_bit;
    logic        watchdog_lock_bit;
    logic [2:0]  timebase_select;
    logic        overflow_irq_enable;
    logic [15:0] counter;
    logic [7:0]  counter_snapshot;
    logic [3:0]  div_count;

    // Per-module state
    logic [7:0]  module_mode_reg   [NUM_MODULES];
    logic [7:0]  compare_low_byte  [NUM_MODULES];
    logic [7:0]  compare_high_byte [NUM_MODULES];

    // Next values
    logic [7:0]  next_module_mode  [NUM_MODULES];
    logic [7:0]  next_compare_low  [NUM_MODULES];
    logic [7:0]  next_compare_high [NUM_MODULES];
    logic [4:0]  next_io_line;
    logic [4:0]  set_event;
    logic [4:0]  next_event_flag;
    logic [15:0] next_counter;
    logic [7:0]  next_rdata;
    logic        next_watchdog_reset;
    compare_mode_t mode [NUM_MODULES];

    // Decode
    wire         wd_on        = watchdog_enable_bit | watchdog_lock_bit;
    wire         run_enable   = (counter_run | wd_on) & ~(idle_suspend & cpu_idle);
    wire         div_last     = (timebase_select == TIMEBASE_DIV12) ? (div_count == DIV12_LAST)
                                                                    : (div_count == DIV4_LAST);
    wire         timebase_src = (timebase_select == TIMEBASE_SYSCLK) ? 1'b1 :
                                (timebase_select == TIMEBASE_DIV12 ||
                                 timebase_select == TIMEBASE_DIV4)   ? div_last : timebase_event;
    wire         advance      = timebase_src & run_enable;
    wire         low_wrap     = (counter[7:0] == 8'hff);
    wire         full_wrap    = (counter == 16'hffff);
    wire         wr_control   = reg_write && (reg_addr == ARRAY_CONTROL_OFS);
    wire         wr_amode     = reg_write && (reg_addr == ARRAY_MODE_OFS);
    wire         wr_cnt_low   = reg_write && (reg_addr == COUNTER_LOW_OFS) && !wd_on;
    wire         wr_cnt_high  = reg_write && (reg_addr == COUNTER_HIGH_OFS) && !wd_on;
    wire         rd_cnt_low   = reg_read && (reg_addr == COUNTER_LOW_OFS);
    wire         wd_force     = wd_on && wr_control && reg_wdata[WATCHDOG_MODULE];
    wire         wd_match     = compare_high_byte[WATCHDOG_MODULE] == counter[15:8];
    wire [3:0]   next_div     = div_last ? 4'h0 : div_count + 4'h1;

    function automatic logic addr_hit(input logic [4:0] base, input int idx);
        return reg_write && (reg_addr == base + 5'(idx));
    endfunction

    // Counter: software writes only while the watchdog is off
    always_comb begin
        next_counter = counter;
        if (wr_cnt_low)
            next_counter = {counter[15:8], reg_wdata};
        else if (wr_cnt_high)
            next_counter = {reg_wdata, counter[7:0]};
        else if (advance)
            next_counter = counter + 16'h0001;
    end

    // Per-module compare engines
    always_comb begin
        for (int i = 0; i < NUM_MODULES; i++) begin
            logic eq16;
            logic eqlow;
            logic ecom;
            logic mat;
            eq16  = (counter == {compare_high_byte[i], compare_low_byte[i]});
            eqlow = (counter[7:0] == compare_low_byte[i]);
            ecom  = module_mode_reg[i][COMPARE_ENABLE_BIT];
            mat   = module_mode_reg[i][EQUAL_EVENT_BIT];
            mode[i] = (wd_on && i == WATCHDOG_MODULE) ? MODE_WATCHDOG
                                                      : decode_mode(module_mode_reg[i]);
            next_io_line[i]      = module_io_line[i];
            next_compare_low[i]  = compare_low_byte[i];
            next_compare_high[i] = compare_high_byte[i];
            next_module_mode[i]  = module_mode_reg[i];
            set_event[i]         = 1'b0;
            if (advance) begin
                unique case (mode[i])
                    MODE_TIMER: begin
                        set_event[i] = eq16;
                    end
                    MODE_HSO: begin
                        if (eq16) begin
                            next_io_line[i] = ~module_io_line[i];
                            set_event[i]    = 1'b1;
                        end
                    end
                    MODE_FREQ: begin
                        if (eqlow) begin
                            next_io_line[i]     = ~module_io_line[i];
                            next_compare_low[i] = compare_low_byte[i] + compare_high_byte[i];
                        end
                    end
                    MODE_PWM8: begin
                        set_event[i] = eqlow && ecom && mat;
                        if (low_wrap) begin
                            next_io_line[i]     = 1'b0;
                            next_compare_low[i] = compare_high_byte[i];
                        end else if (eqlow && ecom) begin
                            next_io_line[i] = 1'b1;
                        end
                    end
                    MODE_PWM16: begin
                        set_event[i] = eq16 && ecom && mat;
                        if (full_wrap)
                            next_io_line[i] = 1'b0;
                        else if (eq16 && ecom)
                            next_io_line[i] = 1'b1;
                    end
                    MODE_OFF, MODE_WATCHDOG: begin
                    end
                endcase
            end
            if (addr_hit(MODULE_MODE_OFS, i) && !(wd_on && i == WATCHDOG_MODULE))
                next_module_mode[i] = reg_wdata;
            if (addr_hit(COMPARE_LOW_OFS, i)) begin
                next_compare_low[i]                     = reg_wdata;
                next_module_mode[i][COMPARE_ENABLE_BIT] = 1'b0;
            end
            if (addr_hit(COMPARE_HIGH_OFS, i)) begin
                if (mode[i] == MODE_WATCHDOG) begin
                    next_compare_high[i] = counter[15:8] + compare_low_byte[i];
                end else begin
                    next_compare_high[i]                    = reg_wdata;
                    next_module_mode[i][COMPARE_ENABLE_BIT] = 1'b1;
                end
            end
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    assign next_event_flag = (wr_control ? (module_event_flag & reg_wdata[4:0]) : module_event_flag)
                             | set_event;

    assign next_watchdog_reset = wd_on && ((advance && low_wrap && wd_match) || wd_force);

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        if (reg_read) begin
            if (reg_addr == ARRAY_CONTROL_OFS)
                next_rdata = {overflow_flag, counter_run, 1'b0, module_event_flag};
            else if (reg_addr == ARRAY_MODE_OFS)
                next_rdata = {idle_suspend, watchdog_enable_bit, watchdog_lock_bit, 1'b0,
                              timebase_select, overflow_irq_enable};
            else if (reg_addr == COUNTER_LOW_OFS)
                next_rdata = counter[7:0];
            else if (reg_addr == COUNTER_HIGH_OFS)
                next_rdata = counter_snapshot;
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (reg_addr == MODULE_MODE_OFS + 5'(i))
                    next_rdata = module_mode_reg[i];
                if (reg_addr == COMPARE_LOW_OFS + 5'(i))
                    next_rdata = compare_low_byte[i];
                if (reg_addr == COMPARE_HIGH_OFS + 5'(i))
                    next_rdata = compare_high_byte[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_MODULES; i++)
            module_io_oe[i] = (mode[i] == MODE_HSO) || (mode[i] == MODE_FREQ) ||
                              (mode[i] == MODE_PWM8) || (mode[i] == MODE_PWM16);
    end

    assign irq_request = |(module_event_flag & {module_mode_reg[4][MODULE_IRQ_BIT],
                                                module_mode_reg[3][MODULE_IRQ_BIT],
                                                module_mode_reg[2][MODULE_IRQ_BIT],
                                                module_mode_reg[1][MODULE_IRQ_BIT],
                                                module_mode_reg[0][MODULE_IRQ_BIT]})
                         | (overflow_flag & overflow_irq_enable);

    // Array registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            overflow_flag       <= 1'b0;
            counter_run         <= 1'b0;
            module_event_flag   <= 5'h00;
            idle_suspend        <= ARRAY_MODE_RESET[IDLE_SUSPEND_BIT];
            watchdog_enable_bit <= ARRAY_MODE_RESET[WD_ENABLE_BIT];
            watchdog_lock_bit   <= ARRAY_MODE_RESET[WD_LOCK_BIT];
            timebase_select     <= ARRAY_MODE_RESET[TIMEBASE_LSB +: 3];
            overflow_irq_enable <= ARRAY_MODE_RESET[OVERFLOW_IRQ_BIT];
        end else begin
            overflow_flag     <= (wr_control ? (overflow_flag & reg_wdata[OVERFLOW_FLAG_BIT]) : overflow_flag)
                                 | (advance & full_wrap);
            module_event_flag <= next_event_flag;
            if (wr_control)
                counter_run <= reg_wdata[COUNTER_RUN_BIT];
            if (wr_amode) begin
                watchdog_enable_bit <= reg_wdata[WD_ENABLE_BIT];
                watchdog_lock_bit   <= watchdog_lock_bit | reg_wdata[WD_LOCK_BIT];
                overflow_irq_enable <= reg_wdata[OVERFLOW_IRQ_BIT];
                if (!wd_on) begin
                    idle_suspend    <= reg_wdata[IDLE_SUSPEND_BIT];
                    timebase_select <= reg_wdata[TIMEBASE_LSB +: 3];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            counter          <= COUNTER_RESET;
            counter_snapshot <= 8'h00;
            div_count        <= 4'h0;
            reg_rdata        <= 8'h00;
            watchdog_reset   <= 1'b0;
            module_io_line   <= 5'h00;
        end else begin
            counter        <= next_counter;
            div_count      <= next_div;
            reg_rdata      <= next_rdata;
            watchdog_reset <= next_watchdog_reset;
            module_io_line <= next_io_line;
            if (rd_cnt_low)
                counter_snapshot <= counter[15:8];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                module_mode_reg[i]   <= MODULE_MODE_RESET;
                compare_low_byte[i]  <= COMPARE_RESET;
                compare_high_byte[i] <= COMPARE_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                module_mode_reg[i]   <= next_module_mode[i];
                compare_low_byte[i]  <= next_compare_low[i];
                compare_high_byte[i] <= next_compare_high[i];
            end
        end
    end

    // Checks on the modules the bench drives in each mode, and the watchdog
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    wire no_write = !reg_write;

    sequence wd_overflow_match;
        wd_on && advance && low_wrap && wd_match;
    endsequence

    sequence pwm8_wrap;
        advance && mode[3] == MODE_PWM8 && low_wrap && no_write;
    endsequence

    chk_timer_flag_set: assert property (
        advance && mode[0] == MODE_TIMER && counter == {compare_high_byte[0], compare_low_byte[0]}
        |=> module_event_flag[0] && (irq_request || !module_mode_reg[0][MODULE_IRQ_BIT]))
        else $error("timer match did not set event flag");

    chk_flag_stays_set: assert property (
        module_event_flag[0] && !wr_control |=> module_event_flag[0])
        else $error("event flag dropped without software clear");

    chk_low_write_clears: assert property (
        reg_write && reg_addr == COMPARE_LOW_OFS |=> !module_mode_reg[0][COMPARE_ENABLE_BIT])
        else $error("low byte write left compare enable set");

    chk_high_write_sets: assert property (
        reg_write && reg_addr == COMPARE_HIGH_OFS |=> module_mode_reg[0][COMPARE_ENABLE_BIT])
        else $error("high byte write left compare enable clear");

    chk_hso_flip: assert property (
        advance && mode[1] == MODE_HSO && counter == {compare_high_byte[1], compare_low_byte[1]}
        |=> module_io_line[1] != $past(module_io_line[1]))
        else $error("high speed output did not flip");

    chk_freq_advance: assert property (
        advance && mode[2] == MODE_FREQ && counter[7:0] == compare_low_byte[2] && no_write
        |=> compare_low_byte[2] == 8'($past(compare_low_byte[2]) + $past(compare_high_byte[2]))
            && module_io_line[2] != $past(module_io_line[2]))
        else $error("frequency output step wrong");

    chk_pwm8_wrap: assert property (
        pwm8_wrap |=> !module_io_line[3] && compare_low_byte[3] == $past(compare_high_byte[3]))
        else $error("8-bit modulator wrap wrong");

    chk_pwm_zero_duty: assert property (
        (mode[4] == MODE_PWM8 || mode[4] == MODE_PWM16) && !module_mode_reg[4][COMPARE_ENABLE_BIT]
        && !module_io_line[4] |=> !module_io_line[4])
        else $error("modulator rose with compare disabled");

    chk_pwm16_high: assert property (
        advance && mode[0] == MODE_PWM16 && module_mode_reg[0][COMPARE_ENABLE_BIT] && !full_wrap
        && counter == {compare_high_byte[0], compare_low_byte[0]} |=> module_io_line[0])
        else $error("16-bit modulator missed match");

    chk_wd_timeout: assert property (
        wd_overflow_match |=> watchdog_reset)
        else $error("watchdog timeout missed");

    chk_wd_lock_hold: assert property (
        watchdog_lock_bit |=> (watchdog_lock_bit && wd_on) [*2])
        else $error("locked watchdog was disabled");

    chk_wd_update: assert property (
        wd_on && reg_write && reg_addr == COMPARE_HIGH_OFS + 5'h04
        |=> compare_high_byte[4] == 8'($past(counter[15:8]) + $past(compare_low_byte[4])))
        else $error("watchdog update load wrong");

    chk_wd_force: assert property (
        wd_on && wr_control && reg_wdata[4] |=> watchdog_reset)
        else $error("forced watchdog reset missing");

    chk_wd_counter_lock: assert property (
        wd_on && reg_write && reg_addr == COUNTER_LOW_OFS && !advance |=> $stable(counter))
        else $error("counter written while watchdog on");

    chk_idle_compare: assert property (
        !advance && no_write |=> $stable(module_io_line) && $stable(compare_low_byte[0]))
        else $error("compare acted without advance pulse");

endmodule

/* sim/io_line_watch.sv */
// Far-side sensor on the module io lines: rise counts and last high width
`timescale 1ns/10ps
module io_line_watch (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic [4:0]  module_io_line,
    output logic      [15:0] rises    [5],
    output logic      [15:0] high_len [5]
);
    logic [4:0]  prev;
    logic [15:0] run [5];
    // Sensor only: it never drives a line back toward the block
    always_ff @(posedge mclk or posedge reset) begin
        for (int i = 0; i < 5; i++) begin
            if (reset) begin
                prev[i]     <= 1'b0;
                run[i]      <= 16'h0000;
                rises[i]    <= 16'h0000;
                high_len[i] <= 16'h0000;
            end else begin
                prev[i] <= module_io_line[i];
                run[i]  <= (module_io_line[i] != prev[i]) ? 16'h0001 : run[i] + 16'h0001;
                if (module_io_line[i] && !prev[i])
                    rises[i] <= rises[i] + 16'h0001;
                if (!module_io_line[i] && prev[i])
                    high_len[i] <= run[i];
            end
        end
    end
endmodule

/* sim/tb.sv */
// Testbench for the counter array compare and watchdog block
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    import counter_array_pkg::*;
    logic       mclk = 0, reset = 1, reg_write = 0, reg_read = 0;
    logic [4:0] reg_addr = 5'h00, module_io_line, module_io_oe;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, q;
    logic       irq_request, watchdog_reset, seen;
    logic       cpu_idle = 0, tb_event = 0;
    logic [15:0] rises [5], high_len [5];
    int         mismatches = 0, checks_done = 0, cnt;
    logic [8:0] rows [8] = '{9'h000, 9'h090, 9'h099, 9'h08d, 9'h085, 9'h185, 9'h0c0, 9'h00c};
    always #20 mclk = ~mclk;
    counter_array_compare_watchdog dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .cpu_idle(cpu_idle), .timebase_event(tb_event), .module_io_line(module_io_line),
        .module_io_oe(module_io_oe), .irq_request(irq_request), .watchdog_reset(watchdog_reset));
    io_line_watch far (.mclk(mclk), .reset(reset), .module_io_line(module_io_line),
        .rises(rises), .high_len(high_len));
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
    endtask
    task automatic pulse_event();
        @(posedge mclk);
        tb_event <= 1'b1;
        @(posedge mclk);
        tb_event <= 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        mismatches++;
        test_done();
    end
    initial begin
        do_reset();
        cnt = 0;
        while (cnt < 4000 && watchdog_reset !== 1'b1) begin
            @(posedge mclk);
            #1 cnt++;
        end
        `CHK(cnt >= 3060 && cnt <= 3090, 1'b1)
        rd(ARRAY_MODE_OFS, d);
        `CHK(d, 8'h40)
        wr(ARRAY_MODE_OFS, 8'hc8);
        rd(ARRAY_MODE_OFS, d);
        `CHK(d, 8'h40)
        rd(ARRAY_CONTROL_OFS, d);
        `CHK(d[COUNTER_RUN_BIT], 1'b0)
        @(posedge mclk);
        reg_addr  <= ARRAY_CONTROL_OFS;
        reg_wdata <= 8'h10;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            #1 seen = seen | watchdog_reset;
            @(posedge mclk);
        end
        `CHK(seen, 1'b1)
        wr(ARRAY_MODE_OFS, 8'h00);
        wr(ARRAY_MODE_OFS, 8'h08);
        rd(ARRAY_MODE_OFS, d);
        `CHK(d, 8'h08)
        foreach (rows[i]) begin
            wr(MODULE_MODE_OFS, rows[i][8:1]);
            `CHK(module_io_oe[0], rows[i][0])
        end
        wr(COUNTER_LOW_OFS, 8'h00);
        wr(COUNTER_HIGH_OFS, 8'h00);
        // Per module: mode, then compare low, then compare high
        wr(5'h04, 8'h49); wr(5'h09, 8'h14); wr(5'h0e, 8'h00);
        wr(5'h05, 8'h4c); wr(5'h0a, 8'h18); wr(5'h0f, 8'h00);
        wr(5'h06, 8'h46); wr(5'h0b, 8'h20); wr(5'h10, 8'h10);
        wr(5'h07, 8'h42); wr(5'h0c, 8'h80); wr(5'h11, 8'h40);
        // Compare high first, then low: low leaves compare disabled
        wr(5'h08, 8'h42); wr(5'h12, 8'h00); wr(5'h0d, 8'h00);
        wr(ARRAY_CONTROL_OFS, 8'h40);
        repeat (700) @(posedge mclk);
        @(negedge mclk);
        rd(ARRAY_CONTROL_OFS, d);
        `CHK(d[0], 1'b1)
        `CHK(irq_request, 1'b1)
        `CHK(module_io_line[1], 1'b1)
        `CHK(high_len[2], 16'h0010)
        `CHK(high_len[3], 16'h00bf)
        `CHK(rises[4], 16'h0000)
        wr(ARRAY_CONTROL_OFS, 8'h40);
        `CHK(irq_request, 1'b0)
        wr(MODULE_MODE_OFS, 8'hcb);
        wr(COMPARE_LOW_OFS, 8'h00);
        wr(COMPARE_HIGH_OFS, 8'h03);
        repeat (100) @(posedge mclk);
        @(negedge mclk);
        `CHK(module_io_line[0], 1'b1)
        `CHK(irq_request, 1'b1)
        wr(ARRAY_MODE_OFS, 8'h8a);
        rd(COUNTER_LOW_OFS, d);
        repeat (3) pulse_event();
        rd(COUNTER_LOW_OFS, q);
        `CHK(q, d + 8'h03)
        @(posedge mclk);
        cpu_idle <= 1'b1;
        pulse_event();
        rd(COUNTER_LOW_OFS, d);
        `CHK(d, q)
        do_reset();
        wr(ARRAY_MODE_OFS, 8'h60);
        wr(ARRAY_MODE_OFS, 8'h08);
        rd(ARRAY_MODE_OFS, d);
        `CHK(d, 8'h20)
        wr(5'h0d, 8'h02);
        wr(5'h12, 8'h00);
        rd(5'h12, d);
        `CHK(d, 8'h02)
        wr(COUNTER_LOW_OFS, 8'h55);
        wr(COUNTER_HIGH_OFS, 8'h55);
        rd(COUNTER_LOW_OFS, d);
        rd(COUNTER_HIGH_OFS, q);
        `CHK(q, 8'h00)
        `CHK(d < 8'h10, 1'b1)
        test_done();
    end
endmodule
